// *** sqc_dev.sv ***
// Functional notes
// RULE1: measurement period 32/16/8/4 minutes by select
// RULE2: measure temperature immediately after power-on
// RULE3: compensation idle for first 60 seconds
// RULE4: add/remove oscillator pulses, evenly spread
// RULE5: at most one-cycle correction each second
// RULE6: square wave from uncompensated oscillator
// RULE7: disable accepted within 5 s of reset
// RULE8: reload starts on 0-to-1 bit write
// RULE9: reload bit reads 0 until copy done
// RULE10: reload completes in under 100 ms
// RULE11: reload logic ignores software reset
// RULE12: host keeps reload bit at 1
// RULE13: host reloads once after stable power-up
// RULE14: frequency select table, 111 is off
// RULE15: push-pull output, on from power-on
// RULE16: divided outputs have 50:50 duty
// RULE17: unused bits read as zero
// RULE18: reload bit unchanged by later resets
// RULE19: host keeps spare bit 4 at 0
// RULE20: aging trim 2 ppm steps, 8 neutral
// RULE21: host routes seconds pulse for observation; sqc_host has no such route, second_o leaves the device only
// RULE22: frequency changes without runt pulses
`timescale 1ns/10ps
`default_nettype none
module sqc_dev #(
  parameter int unsigned RELOAD_CYC = sqc_pkg::RELOAD_CYCLES  // Reload copy time
) (
  input  wire logic              clk_i,         // 50 MHz clock
  input  wire logic              srst_i,        // Power-on reset, sync high
  input  wire logic              osc_i,         // 32.768 kHz crystal pin
  input  wire logic              meas_valid_i,  // Sensor result strobe
  input  wire logic signed [7:0] meas_hppm_i,   // Needed correction, 0.5 ppm
  input  wire logic [15:0]       fuse_word_i,   // Fuse calibration data
  output logic                   meas_req_o,    // Start a measurement
  output logic                   second_o,      // Compensated 1 Hz tick
  output logic                   comp_on_o,     // Compensation running
  output logic [15:0]            calib_o,       // Shadow calibration word
  sqc_if.dev                     bus            // Register side
);
  // ==================================================================
  // Oscillator synchroniser
  logic s1_reg, s2_reg, s3_reg;  // Three-stage chain
  logic osc_reg, osc_next;       // Accepted level
  logic osc_rise;                // Rising edge of accepted level
  // Level accepted only when stages two and three agree
  always_comb begin
    osc_next = (s2_reg == s3_reg) ? s2_reg : osc_reg;
    osc_rise = osc_next & ~osc_reg;
  end
  always_ff @(posedge clk_i) begin
    s1_reg  <= osc_i;
    s2_reg  <= s1_reg;
    s3_reg  <= s2_reg;
    osc_reg <= srst_i ? 1'b0 : osc_next;
  end

  // ==================================================================
  // Control registers
  logic [1:0] tsel_reg, tsel_next;  // temp_meas_period_sel
  logic [2:0] fsel_reg, fsel_next;  // square_freq_sel as written
  logic [3:0] trim_reg, trim_next;  // aging_trim_value
  logic       wr_ctl, wr_age;       // Decoded writes
  always_comb begin
    wr_ctl    = bus.reg_wr && (bus.reg_addr == sqc_pkg::ADDR_CLK_CTL);
    wr_age    = bus.reg_wr && (bus.reg_addr == sqc_pkg::ADDR_AGING);
    tsel_next = tsel_reg;
    fsel_next = fsel_reg;
    trim_next = trim_reg;
    if (bus.soft_reset_cmd) begin
      // Software reset returns fields to defaults
      tsel_next = sqc_pkg::TSEL_RST;
      fsel_next = sqc_pkg::FREQ_RST;
      trim_next = sqc_pkg::AGING_RST;
    end else begin
      if (wr_ctl) begin
        tsel_next = bus.reg_wdata[sqc_pkg::TSEL_LSB +: 2];
        fsel_next = bus.reg_wdata[sqc_pkg::FREQ_LSB +: 3];
      end
      if (wr_age) begin
        trim_next = bus.reg_wdata[3:0];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tsel_reg <= sqc_pkg::TSEL_RST;
      fsel_reg <= sqc_pkg::FREQ_RST;
      trim_reg <= sqc_pkg::AGING_RST;
    end else begin
      tsel_reg <= tsel_next;
      fsel_reg <= fsel_next;
      trim_reg <= trim_next;
    end
  end

  // ==================================================================
  // Calibration reload, cleared by power-on reset only
  logic        rl_bit_reg, rl_bit_next;  // Visible reload bit
  logic        rl_busy_reg, rl_busy_next;
  logic [22:0] rl_cnt_reg, rl_cnt_next;  // Copy timer
  logic [15:0] calib_reg, calib_next;    // Shadow word
  always_comb begin
    rl_bit_next  = rl_bit_reg;
    rl_busy_next = rl_busy_reg;
    rl_cnt_next  = rl_cnt_reg;
    calib_next   = calib_reg;
    if (rl_busy_reg) begin
      if (rl_cnt_reg >= 23'(RELOAD_CYC - 1)) begin
        // Copy done, bit reads 1; completion beats a 0 write
        calib_next   = fuse_word_i;                           // RULE10
        rl_busy_next = 1'b0;
        rl_bit_next  = 1'b1;                                  // RULE9
      end else begin
        rl_cnt_next = rl_cnt_reg + 23'h000001;
      end
    end else if (wr_ctl) begin
      // Write 1 over a 0 starts a copy; a 0 write parks the bit
      if (bus.reg_wdata[sqc_pkg::RELOAD_BIT] && !rl_bit_reg) begin
        rl_busy_next = 1'b1;                                  // RULE8
        rl_cnt_next  = 23'h000000;
      end else if (!bus.reg_wdata[sqc_pkg::RELOAD_BIT]) begin
        rl_bit_next = 1'b0;
      end
    end
  end
  // Soft reset is deliberately absent from this process
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rl_bit_reg  <= 1'b0;                                    // RULE11
      rl_busy_reg <= 1'b1;                                    // RULE9
      rl_cnt_reg  <= 23'h000000;
      calib_reg   <= 16'h0000;
    end else begin
      rl_bit_reg  <= rl_bit_next;                             // RULE18
      rl_busy_reg <= rl_busy_next;
      rl_cnt_reg  <= rl_cnt_next;
      calib_reg   <= calib_next;
    end
  end

  // ==================================================================
  // Square wave from the raw oscillator divider
  logic [14:0] div_reg, div_next;  // Uncompensated divider
  logic [2:0]  fcur_reg, fcur_next;  // Selection in force
  logic        sq_reg, sq_next;
  logic        slow;                 // Change involves 1 Hz
  always_comb begin
    div_next  = osc_rise ? div_reg + 15'h0001 : div_reg;      // RULE6
    fcur_next = fcur_reg;
    slow      = (fcur_reg == sqc_pkg::FREQ_1HZ) || (fsel_reg == sqc_pkg::FREQ_1HZ);
    // Switch only at a common period end, so no runt appears
    if (osc_rise && (fsel_reg != fcur_reg) &&
        ((slow && (&div_reg)) || (!slow && (&div_reg[4:0])))) begin
      fcur_next = fsel_reg;                                   // RULE22
    end
    case (fcur_next)
      3'h0:    sq_next = osc_next;                            // RULE16
      3'h1:    sq_next = div_next[0];                         // RULE14
      3'h2:    sq_next = div_next[1];
      3'h3:    sq_next = div_next[2];
      3'h4:    sq_next = div_next[3];
      3'h5:    sq_next = div_next[4];
      3'h6:    sq_next = div_next[14];
      default: sq_next = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_reg  <= 15'h0000;
      fcur_reg <= sqc_pkg::FREQ_RST;
      sq_reg   <= 1'b0;
    end else begin
      div_reg  <= div_next;
      fcur_reg <= fcur_next;
      sq_reg   <= sq_next;
    end
  end
  assign bus.square_wave_out = sq_reg;
  assign bus.square_wave_oe  = (fcur_reg != sqc_pkg::FREQ_HIZ);  // RULE15

  // ==================================================================
  // Compensated timekeeping, measurement schedule, disable window
  logic [15:0]        sec_reg, sec_next;    // Edges in this second
  logic [15:0]        last_reg, last_next;  // Final count; wide enough for 32769 edges
  logic signed [15:0] acc_reg, acc_next;    // Correction accumulator
  logic signed [7:0]  temp_reg, temp_next;  // Latest sensor result
  logic [10:0]        mcnt_reg, mcnt_next;  // Seconds since last measurement
  logic               mreq_reg, mreq_next;
  logic [5:0]         warm_reg, warm_next;  // Start-up seconds
  logic [2:0]         win_reg, win_next;    // Seconds since soft reset
  logic               wopen_reg, wopen_next;
  logic               cdis_reg, cdis_next;  // comp_disable_bit state
  logic               tick_reg, tick_next;
  logic               sec_end, active;
  logic [10:0]        mper;                 // Period in seconds
  logic signed [15:0] age_h;                // Aging trim in 0.5 ppm
  always_comb begin
    sec_end    = osc_rise && (sec_reg == last_reg);
    active     = (warm_reg == 6'(sqc_pkg::STARTUP_SEC)) && !cdis_reg;   // RULE3
    mper       = 11'(sqc_pkg::MEAS_MAX_SEC) >> tsel_reg;              // RULE1
    // Each trim step is 2 ppm, code 8 neutral
    age_h      = 16'sd32 - $signed({10'h000, trim_reg, 2'b00});        // RULE20
    sec_next   = osc_rise ? (sec_end ? 16'h0000 : sec_reg + 16'h0001) : sec_reg;
    last_next  = last_reg;
    acc_next   = acc_reg;
    temp_next  = meas_valid_i ? meas_hppm_i : temp_reg;
    mcnt_next  = mcnt_reg;
    mreq_next  = 1'b0;
    warm_next  = warm_reg;
    win_next   = win_reg;
    wopen_next = wopen_reg;
    cdis_next  = cdis_reg;
    tick_next  = sec_end;
    if (sec_end) begin
      last_next = 16'h7FFF;
      if (active) begin
        acc_next = acc_reg + 16'(temp_reg) + age_h;
        // One oscillator cycle per second at most, spread by the accumulator
        if (acc_next >= 16'sd61) begin
          acc_next  = acc_next - 16'(sqc_pkg::STEP_HPPM);
          last_next = 16'h7FFE;                               // RULE4
        end else if (acc_next <= -16'sd61) begin
          acc_next  = acc_next + 16'(sqc_pkg::STEP_HPPM);
          last_next = 16'h8000;                               // RULE5
        end
      end
      if (warm_reg != 6'(sqc_pkg::STARTUP_SEC)) begin
        warm_next = warm_reg + 6'h01;
      end
      if (mcnt_reg + 11'h001 >= mper) begin
        mcnt_next = 11'h000;
        mreq_next = 1'b1;
      end else begin
        mcnt_next = mcnt_reg + 11'h001;
      end
      if (wopen_reg) begin
        win_next   = win_reg + 3'h1;
        wopen_next = (win_reg + 3'h1) < 3'(sqc_pkg::DIS_WIN_SEC);
      end
    end
    if (bus.soft_reset_cmd) begin
      win_next   = 3'h0;
      wopen_next = 1'b1;
      cdis_next  = 1'b0;
    end else if (bus.comp_disable_bit && wopen_reg) begin
      cdis_next = 1'b1;                                       // RULE7
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sec_reg   <= 16'h0000;
      last_reg  <= 16'h7FFF;
      acc_reg   <= 16'sh0000;
      temp_reg  <= 8'sh00;
      mcnt_reg  <= 11'h000;
      mreq_reg  <= 1'b1;                                      // RULE2
      warm_reg  <= 6'h00;
      win_reg   <= 3'h0;
      wopen_reg <= 1'b0;
      cdis_reg  <= 1'b0;
      tick_reg  <= 1'b0;
    end else begin
      sec_reg   <= sec_next;
      last_reg  <= last_next;
      acc_reg   <= acc_next;
      temp_reg  <= temp_next;
      mcnt_reg  <= mcnt_next;
      mreq_reg  <= mreq_next;
      warm_reg  <= warm_next;
      win_reg   <= win_next;
      wopen_reg <= wopen_next;
      cdis_reg  <= cdis_next;
      tick_reg  <= tick_next;
    end
  end

  // ==================================================================
  // Read-back and outputs
  always_comb begin
    case (bus.reg_addr)
      sqc_pkg::ADDR_CLK_CTL: bus.reg_rdata = {tsel_reg, rl_bit_reg, 2'b00, fsel_reg};  // RULE17
      sqc_pkg::ADDR_AGING:   bus.reg_rdata = {4'h0, trim_reg};
      default:               bus.reg_rdata = 8'h00;
    endcase
  end
  assign meas_req_o = mreq_reg;
  assign second_o   = tick_reg;
  assign comp_on_o  = active;
  assign calib_o    = calib_reg;
endmodule : sqc_dev
`default_nettype wire

// *** sqc_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module sqc_host (
  input  wire logic             clk_i,         // 50 MHz clock
  input  wire logic             srst_i,        // Sync reset, high
  input  wire logic             osc_stable_i,  // Oscillator settled
  input  wire logic             cmd_valid_i,   // Command request
  input  wire sqc_pkg::sqc_cmd_t cmd_op_i,     // Command kind
  input  wire logic [7:0]       cmd_addr_i,    // Register address
  input  wire logic [7:0]       cmd_data_i,    // Write data
  output logic                  cmd_ready_o,   // Idle, command taken
  output logic                  rsp_valid_o,   // Command finished pulse
  output logic [7:0]            rsp_data_o,    // Read result
  sqc_if.host                   bus            // Device side
);
  // ==================================================================
  // Sequencer
  typedef enum logic [2:0] {
    H_IDLE, H_WR, H_RD, H_RL_RD, H_RL_W0, H_RL_W1, H_RL_POLL, H_DIS
  } sqc_hst_t;
  sqc_hst_t   st_reg, st_next;
  logic [7:0] addr_reg, addr_next;  // Held address
  logic [7:0] data_reg, data_next;  // Held data or read result
  logic       boot_reg, boot_next;  // Power-up reload still owed
  logic       done_reg, done_next;
  logic       dis_last_reg;         // Finished command was compensation off
  logic       ctl;                  // Held address is the output-control register
  always_comb begin
    st_next   = st_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    boot_next = boot_reg;
    done_next = 1'b0;
    ctl       = (addr_reg == sqc_pkg::ADDR_CLK_CTL);
    case (st_reg)
      H_IDLE: begin
        if (boot_reg && osc_stable_i) begin
          // One reload once the crystal runs steadily
          boot_next = 1'b0;                                   // RULE13
          addr_next = sqc_pkg::ADDR_CLK_CTL;
          st_next   = H_RL_RD;
        end else if (cmd_valid_i) begin
          addr_next = cmd_addr_i;
          data_next = cmd_data_i;
          case (cmd_op_i)
            sqc_pkg::SQC_CMD_WRITE:  st_next = H_WR;
            sqc_pkg::SQC_CMD_READ:   st_next = H_RD;
            sqc_pkg::SQC_CMD_RELOAD: begin
              addr_next = sqc_pkg::ADDR_CLK_CTL;
              st_next   = H_RL_RD;
            end
            default:                 st_next = H_DIS;
          endcase
        end
      end
      H_WR: begin
        done_next = 1'b1;
        st_next   = H_IDLE;
      end
      H_RD: begin
        data_next = bus.reg_rdata;
        done_next = 1'b1;
        st_next   = H_IDLE;
      end
      H_RL_RD: begin
        data_next = bus.reg_rdata;
        st_next   = H_RL_W0;
      end
      H_RL_W0:   st_next = H_RL_W1;
      H_RL_W1:   st_next = H_RL_POLL;
      H_RL_POLL: begin
        // Wait for the device to report the copy finished
        if (bus.reg_rdata[sqc_pkg::RELOAD_BIT]) begin
          data_next = bus.reg_rdata;
          done_next = 1'b1;
          st_next   = H_IDLE;
        end
      end
      H_DIS: begin
        done_next = 1'b1;
        st_next   = H_IDLE;
      end
      default:   st_next = H_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg   <= H_IDLE;
      addr_reg <= 8'h00;
      data_reg <= 8'h00;
      boot_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      boot_reg <= boot_next;
      done_reg <= done_next;
    end
  end

  // ==================================================================
  // Bus drive; spare bit always written 0, reload bit left at 1
  always_comb begin
    bus.reg_addr         = addr_reg;
    bus.reg_wr           = (st_reg == H_WR) || (st_reg == H_RL_W0) || (st_reg == H_RL_W1);
    bus.reg_wdata        = data_reg;
    bus.soft_reset_cmd   = (st_reg == H_DIS);
    // Disable follows the reset by one cycle, far inside the window
    bus.comp_disable_bit = 1'b0;
    if (ctl) begin
      bus.reg_wdata[sqc_pkg::SPARE_BIT] = 1'b0;               // RULE19
      if (st_reg == H_WR) begin
        bus.reg_wdata[sqc_pkg::RELOAD_BIT] = 1'b1;            // RULE12
      end
    end
    if (st_reg == H_RL_W0) begin
      bus.reg_wdata[sqc_pkg::RELOAD_BIT] = 1'b0;              // RULE8
    end else if (st_reg == H_RL_W1) begin
      bus.reg_wdata[sqc_pkg::RELOAD_BIT] = 1'b1;
    end
    if (done_reg && (st_reg == H_IDLE) && dis_last_reg) begin
      bus.comp_disable_bit = 1'b1;                            // RULE7
    end
  end
  // Remembers that the finished command was the compensation-off one
  always_ff @(posedge clk_i) begin
    dis_last_reg <= srst_i ? 1'b0 : (st_reg == H_DIS);
  end
  assign cmd_ready_o = (st_reg == H_IDLE) && !(boot_reg && osc_stable_i);
  assign rsp_valid_o = done_reg;
  assign rsp_data_o  = data_reg;
endmodule : sqc_host
`default_nettype wire

// *** sqc_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface sqc_if;
  // ==================================================================
  // Register port, command strobes and square-wave pin
  logic       reg_wr;            // Write strobe
  logic [7:0] reg_addr;          // Register address
  logic [7:0] reg_wdata;         // Write data
  logic [7:0] reg_rdata;         // Read data for reg_addr
  logic       soft_reset_cmd;    // Software reset pulse
  logic       comp_disable_bit;  // Disable-compensation write pulse
  logic       square_wave_out;   // Square wave level
  logic       square_wave_oe;    // High while driven
  modport dev  (input  reg_wr, reg_addr, reg_wdata, soft_reset_cmd, comp_disable_bit,
                output reg_rdata, square_wave_out, square_wave_oe);
  modport host (output reg_wr, reg_addr, reg_wdata, soft_reset_cmd, comp_disable_bit,
                input  reg_rdata, square_wave_out, square_wave_oe);
endinterface : sqc_if
`default_nettype wire

// *** sqc_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module sqc_monitor (
  input wire logic       clk_i,            // 50 MHz clock
  input wire logic       srst_i,           // Power-on reset
  input wire logic       reg_wr,           // Write strobe
  input wire logic [7:0] reg_addr,         // Register address
  input wire logic [7:0] reg_wdata,        // Write data
  input wire logic [7:0] reg_rdata,        // Read data
  input wire logic       soft_reset_cmd,   // Software reset pulse
  input wire logic       comp_disable_bit, // Disable pulse
  input wire logic       square_wave_out,  // Square wave level
  input wire logic       square_wave_oe    // Drive enable
);
  // ==================================================================
  // Register and command checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire logic ctl = (reg_addr == sqc_pkg::ADDR_CLK_CTL); // Control selected
  wire logic agi = (reg_addr == sqc_pkg::ADDR_AGING);   // Trim selected
  // Reload request is a clear followed by a set
  sequence s_clear_wr; reg_wr && ctl && !reg_wdata[5]; endsequence
  sequence s_set_wr; reg_wr && ctl && reg_wdata[5]; endsequence
  a_ctl_unused_zero: assert property (ctl |-> reg_rdata[4:3] == 2'h0)
    else $error("control unused bits not zero");
  a_aging_unused_zero: assert property (agi |-> reg_rdata[7:4] == 4'h0)
    else $error("trim unused bits not zero");
  a_aging_write_lands: assert property (reg_wr && agi ##1 agi |->
    reg_rdata[3:0] == $past(reg_wdata[3:0])) else $error("trim write lost");
  a_ctl_write_lands: assert property (reg_wr && ctl ##1 ctl |->
    {reg_rdata[7:6], reg_rdata[2:0]} == {$past(reg_wdata[7:6]), $past(reg_wdata[2:0])})
    else $error("control write lost");
  a_soft_defaults: assert property (soft_reset_cmd ##1 ctl |->
    reg_rdata[7:6] == sqc_pkg::TSEL_RST && reg_rdata[2:0] == sqc_pkg::FREQ_RST)
    else $error("soft reset left fields");
  a_reload_kept: assert property (soft_reset_cmd && ctl && reg_rdata[5] ##1 ctl |->
    reg_rdata[5]) else $error("soft reset touched reload bit");
  a_disable_after_reset: assert property (comp_disable_bit |-> $past(soft_reset_cmd))
    else $error("disable without soft reset");
  a_reload_order: assert property (s_clear_wr |-> ##[1:4] s_set_wr)
    else $error("reload bit left clear");
  a_spare_held_zero: assert property (reg_wr && ctl |-> !reg_wdata[4])
    else $error("spare bit written high");
  // Output must be driven while power-on reset holds
  a_oe_power_on: assert property (disable iff (1'b0) srst_i ##1 srst_i |-> square_wave_oe)
    else $error("square wave not driven at power-on");
endmodule : sqc_monitor
`default_nettype wire

// *** sqc_pkg.sv ***
`default_nettype none
package sqc_pkg;
  // ==================================================================
  // Register map
  localparam logic [7:0] ADDR_CLK_CTL   = 8'h13;  // clock_output_control
  localparam logic [7:0] ADDR_AGING     = 8'h30;  // crystal_aging_trim
  // clock_output_control fields
  localparam int         TSEL_LSB       = 6;      // temp_meas_period_sel [7:6]
  localparam int         RELOAD_BIT     = 5;      // calib_reload_bit
  localparam int         SPARE_BIT      = 4;      // Must stay 0 for accuracy
  localparam int         FREQ_LSB       = 0;      // square_freq_sel [2:0]
  localparam logic [1:0] TSEL_RST       = 2'h0;   // 32 min
  localparam logic [2:0] FREQ_RST       = 3'h0;   // 32768 Hz
  localparam logic [2:0] FREQ_1HZ       = 3'h6;   // 1 Hz selection
  localparam logic [2:0] FREQ_HIZ       = 3'h7;   // Output off
  // crystal_aging_trim field
  localparam logic [3:0] AGING_RST      = 4'h8;   // 0 ppm
  // ==================================================================
  // Timing
  localparam int         CLK_HZ         = 50000000;
  localparam int         OSC_HZ         = 32768;           // Crystal rate
  localparam int         MEAS_MAX_MIN   = 32;              // Longest period
  localparam int         MEAS_MAX_SEC   = MEAS_MAX_MIN * 60;
  localparam int         STARTUP_SEC    = 60;              // Comp hold-off
  localparam int         DIS_WIN_SEC    = 5;               // Disable window
  localparam int         RELOAD_MS      = 100;             // Reload bound
  // Longest time rounds down, one cycle kept below the bound
  localparam int         RELOAD_CYCLES  = (RELOAD_MS * (CLK_HZ / 1000)) - 1;
  localparam int         STEP_HPPM      = 61;              // 30.5 ppm in 0.5 ppm
  // ==================================================================
  // Host commands
  typedef enum logic [1:0] {
    SQC_CMD_WRITE,
    SQC_CMD_READ,
    SQC_CMD_RELOAD,
    SQC_CMD_COMP_OFF
  } sqc_cmd_t;
endpackage : sqc_pkg
`default_nettype wire

// *** sqwave_comp_trim_ctl_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module sqwave_comp_trim_ctl_bench;
  // ==================================================================
  // Stimulus and results
  logic              clk_i = 1'b0;   // Clock
  logic              srst_i = 1'b1;  // Reset
  logic              osc_i = 1'b0;   // Crystal level
  logic              meas_valid_i = 1'b0;
  logic signed [7:0] meas_hppm_i = 8'h00;
  logic [15:0]       fuse_word_i = 16'h0000;
  logic              osc_stable_i = 1'b0;  // Crystal reported steady
  logic              cmd_valid_i = 1'b0;
  sqc_pkg::sqc_cmd_t cmd_op_i = sqc_pkg::SQC_CMD_READ;
  logic [7:0]        cmd_addr_i = 8'h00;
  logic [7:0]        cmd_data_i = 8'h00;
  logic              meas_req_o, second_o, comp_on_o, cmd_ready_o, rsp_valid_o;
  logic [15:0]       calib_o;
  logic [7:0]        rsp_data_o, d;
  logic [8:0]        exp_q[$];       // Care bit and expected read data
  logic [8:0]        e;
  int                n_errors = 0, checks = 0, cycles = 0, n, hi, lo;
  always #10 clk_i = ~clk_i;
  // Crystal sped up to 30 cycles a period so divider waits stay short
  always #300 osc_i = ~osc_i;
  sqc_if sqc_if_inst ();
  sqc_dev #(.RELOAD_CYC(20)) sqc_dev_inst (.clk_i(clk_i), .srst_i(srst_i), .osc_i(osc_i),
    .meas_valid_i(meas_valid_i), .meas_hppm_i(meas_hppm_i), .fuse_word_i(fuse_word_i),
    .meas_req_o(meas_req_o), .second_o(second_o), .comp_on_o(comp_on_o), .calib_o(calib_o),
    .bus(sqc_if_inst.dev));
  sqc_host sqc_host_inst (.clk_i(clk_i), .srst_i(srst_i), .osc_stable_i(osc_stable_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .bus(sqc_if_inst.host));
  sqc_monitor sqc_monitor_inst (.clk_i(clk_i), .srst_i(srst_i),
    .reg_wr(sqc_if_inst.reg_wr), .reg_addr(sqc_if_inst.reg_addr),
    .reg_wdata(sqc_if_inst.reg_wdata), .reg_rdata(sqc_if_inst.reg_rdata),
    .soft_reset_cmd(sqc_if_inst.soft_reset_cmd),
    .comp_disable_bit(sqc_if_inst.comp_disable_bit),
    .square_wave_out(sqc_if_inst.square_wave_out),
    .square_wave_oe(sqc_if_inst.square_wave_oe));
  // ==================================================================
  // Shared tasks
  task test_done;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  // Holds the request until ready, then waits for the host to go idle
  task cmd(input sqc_pkg::sqc_cmd_t op, input logic [7:0] a, input logic [7:0] wd,
           input logic [8:0] ex);
    exp_q.push_back(ex);
    @(negedge clk_i);
    {cmd_valid_i, cmd_op_i, cmd_addr_i, cmd_data_i} = {1'b1, op, a, wd};
    while (cmd_ready_o !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    while (cmd_ready_o !== 1'b1) @(negedge clk_i);
  endtask : cmd
  // Counts cycles while the square wave holds a level, bounded
  task hold(input logic v, output int c);
    c = 0;
    while (sqc_if_inst.square_wave_out === v && c < 5000) begin
      @(negedge clk_i);
      c++;
    end
  endtask : hold
  // ==================================================================
  // Response watcher, random sensor traffic and hang guard
  always @(negedge clk_i) if (rsp_valid_o === 1'b1) begin
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF;
    if (e[8]) check(rsp_data_o, e[7:0], "read data");
  end
  always @(negedge clk_i) begin
    meas_valid_i <= ($urandom % 512) == 0;
    meas_hppm_i <= 8'($urandom);
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      test_done();
    end
  end
  // ==================================================================
  // Main sequence
  initial begin
    void'($urandom(81196));
    fuse_word_i = 16'($urandom);
    repeat (10) @(negedge clk_i);
    n = int'(meas_req_o === 1'b1);  // Request stands up to release
    srst_i = 1'b0;
    repeat (40) begin
      @(negedge clk_i);
      if (meas_req_o === 1'b1) n++;
    end
    check(16'(n), 16'h0001, "first measurement");
    cmd(sqc_pkg::SQC_CMD_READ, sqc_pkg::ADDR_CLK_CTL, 8'h00, 9'h120);
    cmd(sqc_pkg::SQC_CMD_READ, sqc_pkg::ADDR_AGING, 8'h00, 9'h108);
    cmd(sqc_pkg::SQC_CMD_READ, 8'h55, 8'h00, 9'h100);
    exp_q.push_back(9'h120);  // Boot reload answer
    osc_stable_i = 1'b1;
    for (int f = 0; f < 7; f++) begin
      d = 8'($urandom);
      d[2:0] = 3'(f);
      cmd(sqc_pkg::SQC_CMD_WRITE, sqc_pkg::ADDR_CLK_CTL, d, 9'h000);
      cmd(sqc_pkg::SQC_CMD_READ, sqc_pkg::ADDR_CLK_CTL, 8'h00, {1'b1, d[7:6], 3'h4, d[2:0]});
    end
    d = 8'($urandom);
    cmd(sqc_pkg::SQC_CMD_WRITE, sqc_pkg::ADDR_AGING, d, 9'h000);
    cmd(sqc_pkg::SQC_CMD_READ, sqc_pkg::ADDR_AGING, 8'h00, {5'h10, d[3:0]});
    // Half of 16384 Hz is one crystal period, 30 cycles
    cmd(sqc_pkg::SQC_CMD_WRITE, sqc_pkg::ADDR_CLK_CTL, 8'h01, 9'h000);
    // Switch waits for a common period end, 32 crystal periods at most
    repeat (1000) @(negedge clk_i);
    repeat (2) begin
      hold(1'b1, n);
      hold(1'b0, n);
    end
    hold(1'b1, hi);
    hold(1'b0, lo);
    check(16'(hi), 16'd30, "high time");
    check(16'(lo), 16'd30, "low time");
    cmd(sqc_pkg::SQC_CMD_WRITE, sqc_pkg::ADDR_CLK_CTL, 8'h07, 9'h000);
    n = 0;
    while (sqc_if_inst.square_wave_oe !== 1'b0 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    check(16'(sqc_if_inst.square_wave_oe), 16'h0000, "output off");
    cmd(sqc_pkg::SQC_CMD_COMP_OFF, sqc_pkg::ADDR_CLK_CTL, 8'h00, 9'h000);
    cmd(sqc_pkg::SQC_CMD_READ, sqc_pkg::ADDR_CLK_CTL, 8'h00, 9'h120);
    check(16'(comp_on_o), 16'h0000, "compensation off");
    fuse_word_i = ~fuse_word_i;  // New fuse data must reach the shadow
    cmd(sqc_pkg::SQC_CMD_RELOAD, sqc_pkg::ADDR_CLK_CTL, 8'h00, 9'h000);
    check(calib_o, fuse_word_i, "shadow word");
    cmd(sqc_pkg::SQC_CMD_READ, sqc_pkg::ADDR_CLK_CTL, 8'h00, 9'h120);
    test_done();
  end
endmodule : sqwave_comp_trim_ctl_bench
`default_nettype wire
